// *** src/tma_cfg.svh ***
`ifndef TMA_CFG_SVH
`define TMA_CFG_SVH

// ----------------------------------------
// channel geometry
// ----------------------------------------
`define TMA_NCH 5
`define TMA_CW 16
`define TMA_ADDR_W 8

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TMA_OFF_RUN 8'h00
`define TMA_OFF_STAT 8'h04
`define TMA_OFF_MASK 8'h08
`define TMA_OFF_PINS 8'h0C
`define TMA_OFF_MODE0 8'h20
`define TMA_OFF_CNT0 8'h40

// ----------------------------------------
// reset values
// ----------------------------------------
`define TMA_RST_MODE 8'h00
`define TMA_RST_CNT 16'h0000
`define TMA_RST_RUN 5'h00
`define TMA_RST_MASK 5'h00

// ----------------------------------------
// field positions and prescaler counts
// ----------------------------------------
`define TMA_PINS_GATE_LSB 5
`define TMA_CNT_STRB 4'h3
`define TMA_F2_MASK 5'h01
`define TMA_DIV8_MASK 5'h07
`define TMA_DIV32_MASK 5'h1F
`define TMA_SUB_LAST 5'h1F

// ----------------------------------------
// bus answers
// ----------------------------------------
`define TMA_RESP_OKAY 2'h0
`define TMA_RESP_SLVERR 2'h2

`endif

// *** src/tma_pkg.sv ***
package tma_pkg;

  typedef enum logic [1:0] {
    TMA_OP_TIMER = 2'h0,
    TMA_OP_EVENT = 2'h1,
    TMA_OP_ONESHOT = 2'h2,
    TMA_OP_PWM = 2'h3
  } tma_op_t;

  typedef enum logic [2:0] {
    TMA_SRC_F1 = 3'h0,
    TMA_SRC_F2 = 3'h1,
    TMA_SRC_DIV8 = 3'h2,
    TMA_SRC_DIV32 = 3'h3,
    TMA_SRC_SUB32 = 3'h4
  } tma_src_t;

  typedef struct packed {
    tma_src_t src;
    logic gate_pol;
    logic gate_en;
    logic pulse_en;
    tma_op_t op_mode_field;
  } tma_mode_t;

  typedef struct packed {
    logic f1;
    logic f2;
    logic mainclock_div8;
    logic mainclock_div32;
    logic subclock_div32;
  } tma_ticks_t;

  typedef enum logic [2:0] {
    TMA_ST_STOP = 3'b001,
    TMA_ST_ARMED = 3'b010,
    TMA_ST_COUNT = 3'b100
  } tma_state_t;

  typedef enum logic [2:0] {
    TMA_R_NONE = 3'h0,
    TMA_R_RUN = 3'h1,
    TMA_R_STAT = 3'h2,
    TMA_R_MASK = 3'h3,
    TMA_R_PINS = 3'h4,
    TMA_R_MODE = 3'h5,
    TMA_R_CNT = 3'h6
  } tma_reg_t;

  typedef struct packed {
    tma_reg_t kind;
    logic [2:0] ch;
  } tma_dec_t;

endpackage : tma_pkg

// *** src/tma_prescaler.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tma_cfg.svh"

module tma_prescaler import tma_pkg::*; (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic subclk_pin, // slow subclock from a pin
  output var tma_ticks_t ticks // one-cycle count-source enables
);

  logic [4:0] main_cnt;
  logic [4:0] sub_cnt;
  logic sub_m;
  logic sub_s;
  logic sub_d;
  logic sub_edge;

  assign sub_edge = sub_s && !sub_d;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      main_cnt <= 5'h00;
    end else begin
      main_cnt <= main_cnt + 5'h01;
    end
  end

  // subclock is asynchronous: two flops, then an edge detector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sub_m <= 1'b0;
      sub_s <= 1'b0;
      sub_d <= 1'b0;
      sub_cnt <= 5'h00;
    end else begin
      sub_m <= subclk_pin;
      sub_s <= sub_m;
      sub_d <= sub_s;
      if (sub_edge) begin
        sub_cnt <= sub_cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ticks <= '0;
    end else begin
      ticks.f1 <= 1'b1;
      ticks.f2 <= (main_cnt & `TMA_F2_MASK) == `TMA_F2_MASK;
      ticks.mainclock_div8 <=
        (main_cnt & `TMA_DIV8_MASK) == `TMA_DIV8_MASK;
      ticks.mainclock_div32 <= main_cnt == `TMA_DIV32_MASK;
      ticks.subclock_div32 <= sub_edge && (sub_cnt == `TMA_SUB_LAST);
    end
  end

endmodule : tma_prescaler
`default_nettype wire

// *** src/tma_channel.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tma_cfg.svh"

module tma_channel import tma_pkg::*; #(
  parameter int CW = `TMA_CW
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic run, // channel run bit
  input wire logic count_en, // qualified count-source tick
  input wire logic wr, // count register write, both low byte strobes set
  input wire logic [CW-1:0] wdata, // value written
  input wire logic pulse_en, // pulse output selected
  output logic [CW-1:0] cnt, // live counter
  output logic [CW-1:0] reload, // reload register
  output logic counting, // first tick since start seen
  output logic underflow, // one-cycle underflow event
  output logic pulse_out // pulse output pin level
);

  tma_state_t state;
  logic early;

  assign counting = state == TMA_ST_COUNT;
  assign early = wr && !counting;
  // a zero reload keeps the counter parked at zero, silent
  assign underflow = count_en && !early && cnt == '0 && reload != '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= TMA_ST_STOP;
    end else begin
      case (state)
        TMA_ST_STOP: if (run) state <= count_en ? TMA_ST_COUNT : TMA_ST_ARMED;
        TMA_ST_ARMED: begin
          if (!run) state <= TMA_ST_STOP;
          else if (count_en) state <= TMA_ST_COUNT;
        end
        TMA_ST_COUNT: if (!run) state <= TMA_ST_STOP;
        default: state <= TMA_ST_STOP;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload <= `TMA_RST_CNT;
    end else if (wr) begin
      reload <= wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= `TMA_RST_CNT;
    end else if (early) begin
      cnt <= wdata;
    end else if (count_en) begin
      cnt <= (cnt == '0) ? reload : cnt - 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_out <= 1'b0;
    end else if (!run || !pulse_en) begin
      pulse_out <= 1'b0;
    end else if (underflow) begin
      pulse_out <= !pulse_out;
    end
  end

endmodule : tma_channel
`default_nettype wire

// *** src/tma_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tma_cfg.svh"

// How it works
// - five independent sixteen-bit timer channels
// - per-channel mode field selects operation
// - timer mode counts selected internal clock
// - decrement per tick, reload and interrupt
// - underflow every n plus one ticks
// - run bit starts and stops counting
// - early writes load reload and counter
// - later writes load only the reload
// - count register read returns live counter
// - gate pin enables or suspends counting
// - pulse pin toggles, low when stopped
// - zero value: no counting, no interrupts

module tma_top import tma_pkg::*; #(
  parameter int NCH = `TMA_NCH,
  parameter int CW = `TMA_CW
) (
  input wire logic aclk, // system clock, 100 MHz
  input wire logic aresetn, // sync reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic subclk_pin, // slow subclock pin
  input wire logic [NCH-1:0] gate_input_pin, // gate pins
  output logic [NCH-1:0] pulse_output_pin, // pulse output pins
  output logic irq // level interrupt
);

  localparam int AW = `TMA_ADDR_W;
  localparam logic [AW-1:0] SPAN = AW'(NCH * 4);

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic tma_dec_t tma_decode(input logic [AW-1:0] a);
    logic [AW-1:0] mo;
    logic [AW-1:0] co;
    mo = a - `TMA_OFF_MODE0;
    co = a - `TMA_OFF_CNT0;
    tma_decode.kind = TMA_R_NONE;
    tma_decode.ch = 3'h0;
    if (a[1:0] != 2'h0) begin
      tma_decode.kind = TMA_R_NONE;
    end else if (a == `TMA_OFF_RUN) begin
      tma_decode.kind = TMA_R_RUN;
    end else if (a == `TMA_OFF_STAT) begin
      tma_decode.kind = TMA_R_STAT;
    end else if (a == `TMA_OFF_MASK) begin
      tma_decode.kind = TMA_R_MASK;
    end else if (a == `TMA_OFF_PINS) begin
      tma_decode.kind = TMA_R_PINS;
    end else if (mo < SPAN) begin
      tma_decode.kind = TMA_R_MODE;
      tma_decode.ch = mo[4:2];
    end else if (co < SPAN) begin
      tma_decode.kind = TMA_R_CNT;
      tma_decode.ch = co[4:2];
    end
  endfunction : tma_decode

  function automatic logic src_tick(input tma_ticks_t t, input tma_src_t s);
    src_tick = 1'b0;
    case (s)
      TMA_SRC_F1: src_tick = t.f1;
      TMA_SRC_F2: src_tick = t.f2;
      TMA_SRC_DIV8: src_tick = t.mainclock_div8;
      TMA_SRC_DIV32: src_tick = t.mainclock_div32;
      TMA_SRC_SUB32: src_tick = t.subclock_div32;
      default: src_tick = 1'b0;
    endcase
  endfunction : src_tick

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic aw_full;
  logic [AW-1:0] aw_addr;
  logic w_full;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_wr;
  logic cnt_ok;
  tma_dec_t wr_dec;
  tma_dec_t rd_dec;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  logic [NCH-1:0] run_flags_reg;
  tma_mode_t channel_mode_reg [NCH];
  logic [NCH-1:0] irq_stat;
  logic [NCH-1:0] irq_mask;
  logic [NCH-1:0] stat_clr;

  tma_ticks_t ticks;
  logic [NCH-1:0] gate_m;
  logic [NCH-1:0] gate_s;
  logic [NCH-1:0] gate_ok;
  logic [NCH-1:0] count_en;
  logic [NCH-1:0] cnt_wr;
  logic [NCH-1:0] counting;
  logic [NCH-1:0] uf_vec;
  logic [CW-1:0] cnt_q [NCH];
  logic [CW-1:0] reload_q [NCH];

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  assign wr_dec = tma_decode(aw_addr);
  assign do_wr = aw_full && w_full && !s_axi_bvalid;
  // a split half-word write would tear the counter value
  assign cnt_ok = wr_dec.kind == TMA_R_CNT &&
    (w_strb & `TMA_CNT_STRB) == `TMA_CNT_STRB;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_addr <= '0;
      w_full <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_full) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_full <= 1'b0;
      end
      if (s_axi_wvalid && !w_full) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_wr) begin
        w_full <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TMA_RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      if (wr_dec.kind == TMA_R_NONE ||
          (wr_dec.kind == TMA_R_CNT && !cnt_ok)) begin
        s_axi_bresp <= `TMA_RESP_SLVERR;
      end else begin
        s_axi_bresp <= `TMA_RESP_OKAY;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_flags_reg <= `TMA_RST_RUN;
    end else if (do_wr && wr_dec.kind == TMA_R_RUN && w_strb[0]) begin
      run_flags_reg <= w_data[NCH-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int k = 0; k < NCH; k++) begin
        channel_mode_reg[k] <= tma_mode_t'(`TMA_RST_MODE);
      end
    end else if (do_wr && wr_dec.kind == TMA_R_MODE && w_strb[0]) begin
      channel_mode_reg[wr_dec.ch] <= tma_mode_t'(w_data[7:0]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= `TMA_RST_MASK;
    end else if (do_wr && wr_dec.kind == TMA_R_MASK && w_strb[0]) begin
      irq_mask <= w_data[NCH-1:0];
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  assign stat_clr = (do_wr && wr_dec.kind == TMA_R_STAT && w_strb[0]) ?
    w_data[NCH-1:0] : '0;

  // a new underflow beats a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~stat_clr) | uf_vec;
      irq <= |(irq_stat & irq_mask);
    end
  end

  // ----------------------------------------
  // count sources and gate pins
  // ----------------------------------------
  tma_prescaler u_pre (
    .aclk(aclk),
    .aresetn(aresetn),
    .subclk_pin(subclk_pin),
    .ticks(ticks)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_m <= '0;
      gate_s <= '0;
    end else begin
      gate_m <= gate_input_pin;
      gate_s <= gate_m;
    end
  end

  // ----------------------------------------
  // channels
  // ----------------------------------------
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    tma_mode_t m;
    assign m = channel_mode_reg[i];
    assign gate_ok[i] = !m.gate_en || (gate_s[i] == m.gate_pol);
    // only timer mode counts; other modes are parked here
    assign count_en[i] = run_flags_reg[i] &&
      m.op_mode_field == TMA_OP_TIMER &&
      src_tick(ticks, m.src) && gate_ok[i];
    assign cnt_wr[i] = do_wr && cnt_ok && wr_dec.ch == 3'(i);

    tma_channel #(.CW(CW)) u_ch (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(run_flags_reg[i]),
      .count_en(count_en[i]),
      .wr(cnt_wr[i]),
      .wdata(w_data[CW-1:0]),
      .pulse_en(m.pulse_en),
      .cnt(cnt_q[i]),
      .reload(reload_q[i]),
      .counting(counting[i]),
      .underflow(uf_vec[i]),
      .pulse_out(pulse_output_pin[i])
    );

    chk_mode_gates:
      assert property (m.op_mode_field != TMA_OP_TIMER |-> !count_en[i])
      else $error("non-timer mode counted");
    chk_src_div32:
      assert property (count_en[i] && m.src == TMA_SRC_DIV32
        |-> ticks.mainclock_div32)
      else $error("count without selected source tick");
    chk_decrement:
      assert property (count_en[i] && !cnt_wr[i] && cnt_q[i] != '0
        |=> cnt_q[i] == $past(cnt_q[i]) - 1'b1)
      else $error("counter did not decrement");
    chk_underflow_load:
      assert property (uf_vec[i] && !cnt_wr[i]
        |=> cnt_q[i] == $past(reload_q[i]) && irq_stat[i])
      else $error("underflow did not reload or flag");
    chk_zero_idle:
      assert property (cnt_q[i] == '0 && reload_q[i] == '0 |-> !uf_vec[i])
      else $error("zero value produced an underflow");
    chk_stop_holds:
      assert property (!run_flags_reg[i] && !cnt_wr[i] |=> $stable(cnt_q[i]))
      else $error("stopped counter changed");
    chk_write_both:
      assert property (cnt_wr[i] && !counting[i]
        |=> cnt_q[i] == $past(w_data[CW-1:0])
          && reload_q[i] == $past(w_data[CW-1:0]))
      else $error("early write did not load counter");
    chk_write_reload:
      assert property (cnt_wr[i] && counting[i] && !count_en[i]
        |=> $stable(cnt_q[i]) && reload_q[i] == $past(w_data[CW-1:0]))
      else $error("late write disturbed the counter");
    chk_gate_blocks:
      assert property (m.gate_en && gate_s[i] != m.gate_pol |-> !count_en[i])
      else $error("gate did not suspend counting");
    chk_pulse_low:
      assert property (!run_flags_reg[i] |=> !pulse_output_pin[i])
      else $error("pulse pin high while stopped");
    chk_pulse_toggle:
      assert property (uf_vec[i] && run_flags_reg[i] && m.pulse_en
        |=> pulse_output_pin[i] != $past(pulse_output_pin[i]))
      else $error("pulse pin missed a toggle");
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_dec = tma_decode(s_axi_araddr);
    next_rdata = 32'h0000_0000;
    next_rresp = `TMA_RESP_OKAY;
    if (rd_dec.kind == TMA_R_RUN) begin
      next_rdata[NCH-1:0] = run_flags_reg;
    end else if (rd_dec.kind == TMA_R_STAT) begin
      next_rdata[NCH-1:0] = irq_stat;
    end else if (rd_dec.kind == TMA_R_MASK) begin
      next_rdata[NCH-1:0] = irq_mask;
    end else if (rd_dec.kind == TMA_R_PINS) begin
      next_rdata[NCH-1:0] = pulse_output_pin;
      next_rdata[`TMA_PINS_GATE_LSB +: NCH] = gate_s;
    end else if (rd_dec.kind == TMA_R_MODE) begin
      next_rdata[7:0] = channel_mode_reg[rd_dec.ch];
    end else if (rd_dec.kind == TMA_R_CNT) begin
      next_rdata[CW-1:0] = cnt_q[rd_dec.ch];
    end else begin
      next_rresp = `TMA_RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `TMA_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // bus checks and covers
  // ----------------------------------------
  chk_read_count:
    assert property (s_axi_arvalid && s_axi_arready
      && rd_dec.kind == TMA_R_CNT && rd_dec.ch == 3'h0
      |=> s_axi_rvalid && s_axi_rdata[CW-1:0] == $past(cnt_q[0]))
    else $error("count read returned a stale value");
  chk_partial_write:
    assert property (do_wr && wr_dec.kind == TMA_R_CNT && !cnt_ok
      |=> s_axi_bvalid && s_axi_bresp == `TMA_RESP_SLVERR && cnt_wr == '0)
    else $error("partial count write was not refused");
  chk_irq_level:
    assert property (|(irq_stat & irq_mask) |=> irq)
    else $error("interrupt not raised");

  cov_underflow: cover property (uf_vec[0] ##1 irq);
  cov_pulse: cover property (pulse_output_pin[0] ##1 !pulse_output_pin[0]);
  cov_gate: cover property (run_flags_reg[0] && !gate_ok[0]);
  cov_late_write: cover property (cnt_wr[0] && counting[0]);

endmodule : tma_top
`default_nettype wire

// *** sim/timer_a_interval_mode_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tma_cfg.svh"

`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
  end end

module timer_a_interval_mode_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [4:0] gate_input_pin = 5'h00;
  logic [3:0] sdiv = 4'h0;
  wire subclk_pin = sdiv[3];
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [4:0] pulse_output_pin;
  logic [33:0] rq[$], mq[$];
  logic [1:0] wq[$];
  logic [33:0] e, mk;
  logic [1:0] eb;
  logic [31:0] seed = 32'h18C43371;
  logic [15:0] n, m;
  int n_mismatch = 0, total_checks = 0, p;
  int dv[5] = '{1, 2, 8, 32, 512};

  tma_top tma_top_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .subclk_pin(subclk_pin),
    .gate_input_pin(gate_input_pin),
    .pulse_output_pin(pulse_output_pin), .irq(irq));

  always #5 aclk = ~aclk;
  // slow subclock: one rising edge every 16 cycles
  always @(posedge aclk) sdiv <= sdiv + 4'h1;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  task automatic to();
    n_mismatch++;
    end_sim();
  endtask : to

  // ----------------------------------------
  // bus master
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    int k;
    bit ad, wd;
    wq.push_back(er);
    ad = 0;
    wd = 0;
    k = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (!ad && s_axi_awready === 1'b1) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready === 1'b1) begin
        wd = 1;
        s_axi_wvalid <= 1'b0;
      end
      if (k > 100) to();
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [33:0] x,
                    input logic [33:0] mk);
    int k;
    rq.push_back(x);
    mq.push_back(mk);
    k = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (k > 100) to();
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask : rd

  // cycles between two toggles of a pulse pin, after two settling toggles
  task automatic period(input int ch, output int q);
    int k;
    logic v;
    for (int i = 0; i < 3; i++) begin
      v = pulse_output_pin[ch];
      k = 0;
      while (pulse_output_pin[ch] === v && k < 5000) begin
        @(posedge aclk);
        k++;
      end
      if (k >= 5000) to();
      q = k;
    end
  endtask : period

  // ----------------------------------------
  // response watcher
  // ----------------------------------------
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      mk = mq.pop_front();
      e = rq.pop_front() & mk;
      `CHK("read", e, {s_axi_rresp, s_axi_rdata} & mk)
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
      eb = wq.pop_front();
      `CHK("bresp", eb, s_axi_bresp)
    end
  end

  localparam logic [33:0] ALL = 34'h3FFFFFFFF;
  localparam logic [33:0] ERR = {`TMA_RESP_SLVERR, 32'h0};

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`TMA_OFF_RUN, 34'h0, ALL);
    rd(`TMA_OFF_MASK, 34'h0, ALL);
    rd(`TMA_OFF_MODE0, 34'h0, ALL);
    rd(`TMA_OFF_CNT0, 34'h0, ALL);
    rd(8'h10, ERR, 34'h300000000);
    wr(`TMA_OFF_CNT0, 32'h1234, 4'h1, `TMA_RESP_SLVERR);
    rd(`TMA_OFF_CNT0, 34'h0, ALL);
    $display("test registers done");
    seed = xs(seed);
    n = {14'h0, seed[1:0]} + 16'h1;
    wr(`TMA_OFF_CNT0, {16'h0, n}, 4'hF, `TMA_RESP_OKAY);
    rd(`TMA_OFF_CNT0, {18'h0, n}, ALL);
    wr(`TMA_OFF_MASK, 32'h1, 4'hF, `TMA_RESP_OKAY);
    wr(`TMA_OFF_RUN, 32'h1, 4'hF, `TMA_RESP_OKAY);
    for (int s = 0; s < 5; s++) begin
      wr(`TMA_OFF_MODE0, {24'h0, s[2:0], 5'h04}, 4'hF, `TMA_RESP_OKAY);
      period(0, p);
      `CHK("period", (n + 1) * dv[s], p)
    end
    $display("test sources done");
    wr(`TMA_OFF_MODE0, 32'h04, 4'hF, `TMA_RESP_OKAY);
    `CHK("irq", 1'b1, irq)
    rd(`TMA_OFF_STAT, 34'h1, 34'h1);
    m = n + 16'h2;
    wr(`TMA_OFF_CNT0, {16'h0, m}, 4'hF, `TMA_RESP_OKAY);
    period(0, p);
    `CHK("reload", m + 1, p)
    wr(`TMA_OFF_RUN, 32'h0, 4'hF, `TMA_RESP_OKAY);
    repeat (3) @(posedge aclk);
    `CHK("pin stop", 1'b0, pulse_output_pin[0])
    wr(`TMA_OFF_STAT, 32'h1, 4'hF, `TMA_RESP_OKAY);
    repeat (3) @(posedge aclk);
    `CHK("irq clr", 1'b0, irq)
    $display("test underflow done");
    // gate closed in both polarities: counter must stay put
    wr(`TMA_OFF_CNT0 + 8'h4, 32'h5, 4'hF, `TMA_RESP_OKAY);
    wr(`TMA_OFF_MODE0 + 8'h4, 32'h18, 4'hF, `TMA_RESP_OKAY);
    wr(`TMA_OFF_RUN, 32'h2, 4'hF, `TMA_RESP_OKAY);
    repeat (20) @(posedge aclk);
    rd(`TMA_OFF_CNT0 + 8'h4, 34'h5, ALL);
    // stopped across the swap: pin and polarity are open together only while stopped
    wr(`TMA_OFF_RUN, 32'h0, 4'hF, `TMA_RESP_OKAY);
    gate_input_pin <= 5'h02;
    wr(`TMA_OFF_MODE0 + 8'h4, 32'h08, 4'hF, `TMA_RESP_OKAY);
    wr(`TMA_OFF_RUN, 32'h2, 4'hF, `TMA_RESP_OKAY);
    rd(`TMA_OFF_PINS, 34'h040, 34'h3FF);
    repeat (20) @(posedge aclk);
    rd(`TMA_OFF_CNT0 + 8'h4, 34'h5, ALL);
    gate_input_pin <= 5'h00;
    repeat (20) @(posedge aclk);
    rd(`TMA_OFF_STAT, 34'h2, 34'h2);
    $display("test gate done");
    wr(`TMA_OFF_RUN, 32'h0, 4'hF, `TMA_RESP_OKAY);
    wr(`TMA_OFF_CNT0 + 8'h8, 32'h0, 4'hF, `TMA_RESP_OKAY);
    wr(`TMA_OFF_CNT0 + 8'hC, 32'h3, 4'hF, `TMA_RESP_OKAY);
    wr(`TMA_OFF_MODE0 + 8'h8, 32'h04, 4'hF, `TMA_RESP_OKAY);
    // channel 3 in event mode: not modelled, so it must hold
    wr(`TMA_OFF_MODE0 + 8'hC, 32'h01, 4'hF, `TMA_RESP_OKAY);
    wr(`TMA_OFF_STAT, 32'h1F, 4'hF, `TMA_RESP_OKAY);
    wr(`TMA_OFF_RUN, 32'hC, 4'hF, `TMA_RESP_OKAY);
    repeat (40) @(posedge aclk);
    rd(`TMA_OFF_STAT, 34'h0, 34'h1F);
    rd(`TMA_OFF_CNT0 + 8'hC, 34'h3, ALL);
    `CHK("pin zero", 1'b0, pulse_output_pin[2])
    $display("test zero done");
    end_sim();
  end
endmodule : timer_a_interval_mode_bench

`default_nettype wire
